// ==== hdl/gp_gpio.v ====
// Overview of operation
// - Output pins drive stored output data.
// - Input pins sample pad into input data.
// - Output enable follows direction, or alternate enable when bypassed.
// - Bypass routes pad to alternate peripheral.
// - Set-bits write sets selected output bits.
// - Clear-bits write clears selected output bits.
// - Detect only on enabled input pins.
// - Raw status shows detection while enabled.
// - Masked status needs enable, raw, unmasked.
// - Clear write drops raw and masked status.
// - Trigger bit selects edge or level.
// - Dual-edge bit selects both transitions.
// - Polarity picks rising or falling edge.
// - Level polarity picks high or low.
// - Debounce samples detection on slower tick.
// - Tick rate is clock over divider plus one.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.vh"
module gp_gpio (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [31:0] pad_in,
  output reg  [31:0] pad_out,
  output reg  [31:0] pad_oe,
  input  wire [31:0] alt_oe,
  input  wire [31:0] alt_drive,
  output reg  [31:0] alt_sense,
  output reg         irq
);

  // Every access completes in its first access cycle, so the ready flop is simply held high.
  reg        ready_reg;
  reg        err_reg;
  assign pready  = ready_reg;
  assign pslverr = err_reg;

  reg  [31:0] output_data_reg;
  reg  [31:0] input_data_reg;
  reg  [31:0] pin_direction_reg;
  reg  [31:0] alternate_pass_through_reg;
  reg  [31:0] irq_detect_enable_reg;
  reg  [31:0] irq_raw_status_reg;
  reg  [31:0] irq_block_mask_reg;
  reg  [31:0] irq_edge_or_level_reg;
  reg  [31:0] irq_dual_edge_reg;
  reg  [31:0] irq_polarity_reg;
  reg  [31:0] debounce_enable_reg;
  reg  [31:0] debounce_divider_reg;
  reg  [23:0] div_cnt_reg;
  reg         tick_reg;
  reg  [31:0] sync1_reg;
  reg  [31:0] sync2_reg;
  reg  [31:0] sync3_reg;
  reg  [31:0] stable_reg;
  reg  [31:0] prev_reg;
  reg  [31:0] rd_next;
  reg         rd_ok;

  wire        wr_en = psel & penable & pwrite;
  wire [11:0] ofs   = paddr[`GP_ADDR_MSB:0];
  wire        hit   = (paddr[31:`GP_ADDR_MSB+1] == 20'h00000) && (paddr[1:0] == 2'h0);

  function sel;
    input [11:0] a;
    input [11:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  // Bypassed pins are not inputs, so input data and detection ignore their pad.
  wire [31:0] is_input   = ~pin_direction_reg & ~alternate_pass_through_reg;
  wire [31:0] armed      = irq_detect_enable_reg & is_input;
  wire [31:0] masked_st  = irq_raw_status_reg & irq_detect_enable_reg & ~irq_block_mask_reg;
  wire [31:0] clr_bits   = (wr_en && hit && sel(ofs, `GP_OFS_IRQ_CLR)) ? pwdata : `GP_ZERO32;
  wire        sample_now;
  wire [31:0] detect;

  assign sample_now = 1'b1;

  // Debounce tick: one pulse every divider plus one clocks.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_reg <= `GP_CNT_ZERO;
      tick_reg    <= 1'b0;
    end
    else if (div_cnt_reg >= debounce_divider_reg[23:0])
    begin
      div_cnt_reg <= `GP_CNT_ZERO;
      tick_reg    <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + `GP_CNT_ONE;
      tick_reg    <= 1'b0;
    end
  end

  // Three-stage synchroniser; a change counts once stages two and three agree.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg  <= `GP_ZERO32;
      sync2_reg  <= `GP_ZERO32;
      sync3_reg  <= `GP_ZERO32;
      stable_reg <= `GP_ZERO32;
    end
    else
    begin
      sync1_reg  <= pad_in;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      stable_reg <= (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg | sync3_reg));
    end
  end

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_pin
      // Each pin takes its sample either every clock or on the debounce tick alone.
      wire step = debounce_enable_reg[i] ? tick_reg : sample_now;
      wire cur  = stable_reg[i];
      wire old  = prev_reg[i];
      wire rise = cur & ~old;
      wire fall = ~cur & old;
      wire edg  = irq_dual_edge_reg[i] ? (rise | fall) :
                  (irq_polarity_reg[i] ? fall : rise);
      wire lvl  = irq_polarity_reg[i] ? ~cur : cur;
      assign detect[i] = step & armed[i] & (irq_edge_or_level_reg[i] ? lvl : edg);

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          prev_reg[i] <= 1'b0;
        else if (step)
          prev_reg[i] <= cur;
      end
    end
  endgenerate

  // Raw status: a fresh detection in the clear cycle wins over the clear.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_raw_status_reg <= `GP_ZERO32;
    else
      irq_raw_status_reg <= (irq_raw_status_reg & ~clr_bits) | detect;
  end

  // Register writes.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_data_reg            <= `GP_ZERO32;
      pin_direction_reg          <= `GP_ZERO32;
      alternate_pass_through_reg <= `GP_ZERO32;
      irq_detect_enable_reg      <= `GP_ZERO32;
      irq_block_mask_reg         <= `GP_ZERO32;
      irq_edge_or_level_reg      <= `GP_ZERO32;
      irq_dual_edge_reg          <= `GP_ZERO32;
      irq_polarity_reg           <= `GP_ZERO32;
      debounce_enable_reg        <= `GP_ZERO32;
      debounce_divider_reg       <= `GP_RST_DB_DIV;
    end
    else if (wr_en && hit)
    begin
      case (ofs)
        `GP_OFS_OUT_DATA:  output_data_reg <= pwdata;
        `GP_OFS_SET:       output_data_reg <= output_data_reg | pwdata;
        `GP_OFS_CLEAR:     output_data_reg <= output_data_reg & ~pwdata;
        `GP_OFS_DIR:       pin_direction_reg <= pwdata;
        `GP_OFS_BYPASS:    alternate_pass_through_reg <= pwdata;
        `GP_OFS_IRQ_EN:    irq_detect_enable_reg <= pwdata;
        `GP_OFS_IRQ_MASK:  irq_block_mask_reg <= pwdata;
        `GP_OFS_IRQ_TRIG:  irq_edge_or_level_reg <= pwdata;
        `GP_OFS_IRQ_BOTH:  irq_dual_edge_reg <= pwdata;
        `GP_OFS_IRQ_POL:   irq_polarity_reg <= pwdata;
        `GP_OFS_DB_EN:     debounce_enable_reg <= pwdata;
        `GP_OFS_DB_DIV:    debounce_divider_reg <= pwdata & `GP_DB_DIV_MASK;
        default:           output_data_reg <= output_data_reg;
      endcase
    end
  end

  // Input data follows the synchronised pad on input pins and holds elsewhere.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      input_data_reg <= `GP_ZERO32;
    else
      input_data_reg <= (stable_reg & is_input) | (input_data_reg & ~is_input);
  end

  // Read mux.
  always @*
  begin
    rd_next = `GP_ZERO32;
    rd_ok   = 1'b1;
    case (ofs)
      `GP_OFS_OUT_DATA:   rd_next = output_data_reg;
      `GP_OFS_IN_DATA:    rd_next = input_data_reg;
      `GP_OFS_DIR:        rd_next = pin_direction_reg;
      `GP_OFS_BYPASS:     rd_next = alternate_pass_through_reg;
      `GP_OFS_IRQ_EN:     rd_next = irq_detect_enable_reg;
      `GP_OFS_IRQ_RAW:    rd_next = irq_raw_status_reg;
      `GP_OFS_IRQ_MSK_ST: rd_next = masked_st;
      `GP_OFS_IRQ_MASK:   rd_next = irq_block_mask_reg;
      `GP_OFS_IRQ_TRIG:   rd_next = irq_edge_or_level_reg;
      `GP_OFS_IRQ_BOTH:   rd_next = irq_dual_edge_reg;
      `GP_OFS_IRQ_POL:    rd_next = irq_polarity_reg;
      `GP_OFS_DB_EN:      rd_next = debounce_enable_reg;
      `GP_OFS_DB_DIV:     rd_next = debounce_divider_reg;
      `GP_OFS_SET:        rd_next = `GP_ZERO32;
      `GP_OFS_CLEAR:      rd_next = `GP_ZERO32;
      `GP_OFS_IRQ_CLR:    rd_next = `GP_ZERO32;
      `GP_OFS_RSVD0:      rd_next = `GP_ZERO32;
      `GP_OFS_RSVD1:      rd_next = `GP_ZERO32;
      default:            rd_ok   = 1'b0;
    endcase
    if (!hit)
      rd_ok = 1'b0;
  end

  // Read data and error are registered in the setup cycle so they stand during the access cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata    <= `GP_ZERO32;
      err_reg   <= 1'b0;
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= 1'b1;
      if (psel && !penable)
      begin
        prdata  <= (!pwrite && rd_ok) ? rd_next : `GP_ZERO32;
        err_reg <= ~rd_ok;
      end
      else if (!psel)
        err_reg <= 1'b0;
    end
  end

  // Pad and alternate paths are registered so every output leaves a flop.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out   <= `GP_ZERO32;
      pad_oe    <= `GP_ZERO32;
      alt_sense <= `GP_ZERO32;
      irq       <= 1'b0;
    end
    else
    begin
      pad_out   <= (alternate_pass_through_reg & alt_drive) |
                   (~alternate_pass_through_reg & output_data_reg & pin_direction_reg);
      pad_oe    <= (alternate_pass_through_reg & alt_oe) |
                   (~alternate_pass_through_reg & pin_direction_reg);
      alt_sense <= stable_reg & alternate_pass_through_reg;
      irq       <= |masked_st;
    end
  end

endmodule // gp_gpio
`default_nettype wire

// ==== hdl/gpio_map.vh ====
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH
`define GP_OFS_OUT_DATA    12'h000
`define GP_OFS_IN_DATA     12'h004
`define GP_OFS_DIR         12'h008
`define GP_OFS_BYPASS      12'h00C
`define GP_OFS_SET         12'h010
`define GP_OFS_CLEAR       12'h014
`define GP_OFS_RSVD0       12'h018
`define GP_OFS_RSVD1       12'h01C
`define GP_OFS_IRQ_EN      12'h020
`define GP_OFS_IRQ_RAW     12'h024
`define GP_OFS_IRQ_MSK_ST  12'h028
`define GP_OFS_IRQ_MASK    12'h02C
`define GP_OFS_IRQ_CLR     12'h030
`define GP_OFS_IRQ_TRIG    12'h034
`define GP_OFS_IRQ_BOTH    12'h038
`define GP_OFS_IRQ_POL     12'h03C
`define GP_OFS_DB_EN       12'h040
`define GP_OFS_DB_DIV      12'h044
`define GP_ADDR_MSB        11
`define GP_ZERO32          32'h00000000
`define GP_RST_DB_DIV      32'h000007D0
`define GP_DB_DIV_MASK     32'h00FFFFFF
`define GP_CNT_ONE         24'h000001
`define GP_CNT_ZERO        24'h000000
`endif

// ==== tb/gp_pads.sv ====
`timescale 1ns/1ps
`default_nettype none
// A pin that the device leaves undriven takes the far-side level, which the bench always drives.
module gp_pads (
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  input  wire logic [31:0] ext,
  output logic      [31:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule // gp_pads
`default_nettype wire

// ==== tb/gp_gpio_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module gp_gpio_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] alt_sense
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable & pready & pwrite;
  logic [31:0] wd_q;
  // Holding the last written word lets a check look two edges ahead without a local variable.
  always @(posedge pclk)
    if (acc)
      wd_q <= pwdata;
  a_set_bits: assert property (acc && paddr == 32'h10 |-> ##[1:2] ((pad_out & wd_q & pad_oe) == (wd_q & pad_oe)))
    else $error("set write lost");
  a_clr_bits: assert property (acc && paddr == 32'h14 |-> ##[1:2] ((pad_out & wd_q & pad_oe) == 0))
    else $error("clear write lost");
  a_out_follow: assert property (acc && paddr == 32'h0 |-> ##[1:2] (((pad_out ^ wd_q) & pad_oe) == 0))
    else $error("pad output differs");
  a_oe_dir: assert property (acc && paddr == 32'h8 |-> ##[1:2] (pad_oe == wd_q))
    else $error("enable differs");
  a_alt_quiet: assert property (acc && paddr == 32'hC && pwdata == 0 |-> ##[1:2] (alt_sense == 0))
    else $error("alternate input not idle");
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("wait state");
  a_bad_addr: assert property (psel && penable && (paddr[1:0] != 0 || paddr[31:12] != 0) |-> pslverr && prdata == 0)
    else $error("bad address accepted");
  a_wr_rdata: assert property (psel && penable && pwrite |-> prdata == 0)
    else $error("read data on write");
  a_ready_up: assert property ($past(presetn) |-> pready)
    else $error("ready low");
endmodule // gp_gpio_chk
bind gp_gpio gp_gpio_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_out(pad_out),
  .pad_oe(pad_oe), .alt_sense(alt_sense));
`default_nettype wire

// ==== tb/test_gp_gpio.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module test_gp_gpio;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
  logic [31:0] paddr = 0, pwdata = 0, ext = 0, alt_oe = 0, alt_drive = 0;
  logic [31:0] prdata, pad_in, pad_out, pad_oe, alt_sense, r, seed = 32'h31118F17;
  logic [31:0] m [0:17];
  logic [4:0]  ea = 5'b11101, eb = 5'b11110, ec = 5'b10000;
  int          num_errors = 0, total_checks = 0, cyc = 0, i, k;
  int          rw[$] = '{0, 8, 12, 32, 44, 52, 56, 60, 64, 68};
  gp_gpio dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .alt_oe(alt_oe), .alt_drive(alt_drive), .alt_sense(alt_sense), .irq(irq));
  gp_pads pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext(ext), .pad_in(pad_in));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task end_of_test();
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1, a, d);
    if (a == 16)
      m[0] |= d;
    else if (a == 20)
      m[0] &= ~d;
    else if (a == 68)
      m[17] = d & 32'h00FFFFFF;
    else if (a != 48)
      m[a >> 2] = d;
  endtask
  task rdc(input logic [31:0] a);
    apb(0, a, 0);
    `CHK({e, r}, {1'b0, m[a >> 2]})
  endtask
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  initial
  begin
    for (i = 0; i < 18; i++)
      m[i] = (i == 17) ? 32'h000007D0 : 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 18; i++)
      rdc(32'(i * 4));
    foreach (rw[k])
    begin
      wr(rw[k], rnd() | 1);
      rdc(rw[k]);
    end
    for (k = rw.size() - 1; k >= 0; k--)
      wr(rw[k], rw[k] == 68 ? 32'h7D0 : 0);
    apb(0, 32'h48, 0);
    `CHK({e, r}, 33'h100000000)
    apb(1, 32'h2, 0);
    `CHK(e, 1'b1)
    wr(8, 32'hFFFFFFFF);
    wr(0, 32'h23);
    wr(16, 32'h47);
    `CHK(m[0], 32'h67)
    for (i = 0; i < 8; i++)
    begin
      wr((i % 2) ? 20 : 16, rnd());
      rdc(0);
      `CHK(pad_out, m[0])
    end
    wr(8, rnd());
    @(negedge pclk);
    `CHK(pad_oe, m[2])
    @(posedge pclk);
    wr(8, 0);
    ext <= rnd();
    repeat (8) @(posedge pclk);
    apb(0, 4, 0);
    `CHK(r, ext)
    ext <= 0;
    for (i = 0; i < 5; i++)
    begin
      wr(52, 32'(i > 2));
      wr(56, 32'(i == 2));
      wr(60, 32'(i == 1 || i == 4));
      wr(44, 32'(i == 4));
      wr(48, 1);
      wr(32, 1);
      ext <= 1;
      repeat (8) @(posedge pclk);
      apb(0, 36, 0);
      `CHK(r[0], ea[i])
      wr(48, 1);
      ext <= 0;
      repeat (8) @(posedge pclk);
      apb(0, 36, 0);
      `CHK(r[0], eb[i])
      wr(48, 1);
      repeat (8) @(posedge pclk);
      apb(0, 36, 0);
      `CHK(r[0], ec[i])
      apb(0, 40, 0);
      `CHK(r[0], 1'b0)
      wr(32, 0);
    end
    alt_oe <= rnd();
    alt_drive <= rnd();
    ext <= rnd();
    wr(12, 32'hFFFFFFFF);
    repeat (8) @(posedge pclk);
    `CHK(pad_oe, alt_oe)
    `CHK(alt_sense, (alt_oe & alt_drive) | (~alt_oe & ext))
    end_of_test();
  end
endmodule // test_gp_gpio
`default_nettype wire
